// ==== design/bank_cmd_tracker.v ====
`include "bank_state_regs.vh"
`default_nettype none
module bank_cmd_tracker (
  input  wire        clk,
  input  wire        nrst,
  input  wire        cke,
  input  wire        exitDone,
  input  wire [3:0]  cmd,
  input  wire [1:0]  bankAddr,
  input  wire        autoPre,
  input  wire [7:0]  modeAddr,
  input  wire [31:0] writeData,
  input  wire [3:0]  write_byte_mask,
  output reg  [15:0] bankStates,
  output reg         cmdIllegal,
  output reg  [31:0] storedWord,
  output reg         allIdle
);

  // ***************************************************
  // Input synchronisers
  // ***************************************************
  reg        ckeMeta_q;
  reg        ckeSync_q;
  reg        ckePrev_q;
  reg        exitMeta_q;
  reg        exitSync_q;
  // The clock-enable and exit-done pins pass two flops before any logic sees them
  // The third enable flop keeps last cycle's sample; it and the enable both read the second
  always @(posedge clk) begin
    if (!nrst) begin
      ckeMeta_q  <= 1'b0;
      ckeSync_q  <= 1'b0;
      ckePrev_q  <= 1'b0;
      exitMeta_q <= 1'b0;
      exitSync_q <= 1'b0;
    end else begin
      ckeMeta_q  <= cke;
      ckeSync_q  <= ckeMeta_q;
      ckePrev_q  <= ckeSync_q;
      exitMeta_q <= exitDone;
      exitSync_q <= exitMeta_q;
    end
  end

  // The far side holds exitDone low until the low-power exit time is met;
  // until then commands are neither taken nor flagged
  // Commands take effect only with both clock-enable samples high
  wire cmdEnable = ckeSync_q & ckePrev_q & exitSync_q;

  // ***************************************************
  // Per-bank state and timers
  // ***************************************************
  reg [3:0]  state_q [0:`NUM_BANKS-1];
  reg [3:0]  timer_q [0:`NUM_BANKS-1];
  reg [1:0]  lastBurstBank_q;
  reg        devPowerOn_q;
  wire [`NUM_BANKS-1:0] bankIdle;
  wire [`NUM_BANKS-1:0] bankBurst;
  wire [`NUM_BANKS-1:0] bankBlocking;
  // One-hot bank decode; keeps every compare at the address width
  wire [`NUM_BANKS-1:0] bankSel = 4'h1 << bankAddr;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_BANKS; gi = gi + 1) begin : g_flag
      assign bankIdle[gi]  = (state_q[gi] == `ST_IDLE);
      // Burst states are the only ones that terminate may cut short
      assign bankBurst[gi] = (state_q[gi] == `ST_READING) | (state_q[gi] == `ST_WRITING)
                           | (state_q[gi] == `ST_READ_AP) | (state_q[gi] == `ST_WRITE_AP);
      // Device-wide states that forbid every command but no-op
      assign bankBlocking[gi] = (state_q[gi] == `ST_IDLE_MRR) | (state_q[gi] == `ST_ACT_MRR)
                              | (state_q[gi] == `ST_MRW) | (state_q[gi] == `ST_RST_MRR)
                              | (state_q[gi] == `ST_REFRESH);
    end
  endgenerate

  wire allBanksIdle = &bankIdle;
  wire anyBlocking  = |bankBlocking;
  wire resetCmd     = (cmd == `CMD_MRW) && (modeAddr == `MR_RESET_ADDR);
  // Resetting moves all banks together, so bank 0 speaks for the device
  wire inResetting  = (state_q[0] == `ST_RESETTING);
  wire isNop        = (cmd == `CMD_NOP);

  // Precharge-all legality: every bank idle, active, or precharging
  // An opening or bursting bank cannot be closed yet, so the whole command is refused
  reg preAllOk;
  integer pk;
  always @* begin
    preAllOk = 1'b1;
    for (pk = 0; pk < `NUM_BANKS; pk = pk + 1) begin
      if (bankBurst[pk] || bankBlocking[pk] || state_q[pk] == `ST_ACTING) begin
        preAllOk = 1'b0;
      end
    end
  end

  // Legality of the current command against the addressed bank and the rest
  // Order of the tests matters: power-on admits only the reset write,
  // and a mode access or refresh in flight shuts out everything but no-op
  // Limitation: a mode read aimed at a row-opening or closing bank
  // ends in idle, so the row must be opened again afterwards
  reg legal;
  reg [3:0] tgt;
  always @* begin
    tgt   = state_q[bankAddr];
    legal = 1'b0;
    if (isNop) begin
      legal = 1'b1;
    end else if (devPowerOn_q) begin
      legal = resetCmd;
    end else if (anyBlocking) begin
      legal = 1'b0;
    end else if (inResetting) begin
      legal = (cmd == `CMD_MRR);
    end else begin
      case (cmd)
        `CMD_ACT: legal = (tgt == `ST_IDLE);
        `CMD_RD: legal = (tgt == `ST_ACTIVE) || (tgt == `ST_READING)
                       || (tgt == `ST_WRITING);
        `CMD_WR: legal = (tgt == `ST_ACTIVE) || (tgt == `ST_READING)
                       || (tgt == `ST_WRITING);
        `CMD_PRE: legal = (tgt == `ST_IDLE) || (tgt == `ST_ACTIVE)
                        || (tgt == `ST_PRECHG);
        `CMD_PREALL: legal = preAllOk;
        `CMD_MRR: legal = (tgt == `ST_IDLE) || (tgt == `ST_ACTIVE)
                        || (tgt == `ST_ACTING) || (tgt == `ST_PRECHG);
        `CMD_MRW: legal = allBanksIdle;
        `CMD_BURSTEND: legal = bankBurst[lastBurstBank_q]
                             && (lastBurstBank_q == bankAddr);
        `CMD_REFPB: legal = (tgt == `ST_IDLE);
        `CMD_REFAB: legal = allBanksIdle;
        `CMD_SRE: legal = allBanksIdle;
        default: legal = 1'b0;
      endcase
    end
  end

  // Refused and ignored commands both leave every state untouched
  wire take = cmdEnable && !isNop && legal;

  // Each bank advances on its own timer, reacting to commands it is hit by
  genvar bi;
  generate
    for (bi = 0; bi < `NUM_BANKS; bi = bi + 1) begin : g_bank
      wire hit = take && bankSel[bi];
      // Device-wide commands come first so they reach every bank alike;
      // bank-specific commands only move the bank that the decode selects
      always @(posedge clk) begin
        if (!nrst) begin
          state_q[bi] <= `ST_POWERON;
          timer_q[bi] <= 4'h0;
        end else if (take && resetCmd && devPowerOn_q) begin
          state_q[bi] <= `ST_RESETTING;
          timer_q[bi] <= `RESET_CYC;
        end else if (take && cmd == `CMD_MRR && inResetting) begin
          state_q[bi] <= `ST_RST_MRR;
          timer_q[bi] <= `MODE_READ_CYC;
        end else if (take && cmd == `CMD_MRW) begin
          state_q[bi] <= `ST_MRW;
          timer_q[bi] <= `MODE_WRITE_CYC;
        end else if (take && cmd == `CMD_REFAB) begin
          state_q[bi] <= `ST_REFRESH;
          timer_q[bi] <= `REFRESH_CYC;
        end else if (take && cmd == `CMD_PREALL) begin
          state_q[bi] <= `ST_PRECHG;
          timer_q[bi] <= `PRECHARGE_CYC;
        end else if (hit && cmd == `CMD_ACT) begin
          state_q[bi] <= `ST_ACTING;
          timer_q[bi] <= `ACT_COL_CYC;
        end else if (hit && (cmd == `CMD_RD || cmd == `CMD_WR)) begin
          // Auto-precharge bursts close the row themselves
          if (cmd == `CMD_RD) begin
            state_q[bi] <= autoPre ? `ST_READ_AP : `ST_READING;
          end else begin
            state_q[bi] <= autoPre ? `ST_WRITE_AP : `ST_WRITING;
          end
          timer_q[bi] <= autoPre ? `BURST_CYC + `PRECHARGE_CYC : `BURST_CYC;
        end else if (hit && cmd == `CMD_PRE) begin
          state_q[bi] <= `ST_PRECHG;
          timer_q[bi] <= `PRECHARGE_CYC;
        end else if (hit && cmd == `CMD_MRR) begin
          state_q[bi] <= (state_q[bi] == `ST_ACTIVE) ? `ST_ACT_MRR : `ST_IDLE_MRR;
          timer_q[bi] <= `MODE_READ_CYC;
        end else if (hit && cmd == `CMD_BURSTEND) begin
          state_q[bi] <= `ST_ACTIVE;
          timer_q[bi] <= 4'h0;
        end else if (hit && cmd == `CMD_REFPB) begin
          state_q[bi] <= `ST_REFRESH;
          timer_q[bi] <= `REFRESH_CYC;
        end else if (timer_q[bi] > 4'h1) begin
          timer_q[bi] <= timer_q[bi] - 4'h1;
        end else if (timer_q[bi] == 4'h1) begin
          timer_q[bi] <= 4'h0;
          // Timed states finish into their documented resting state
          case (state_q[bi])
            `ST_ACTING:   state_q[bi] <= `ST_ACTIVE;
            `ST_READING:  state_q[bi] <= `ST_ACTIVE;
            `ST_WRITING:  state_q[bi] <= `ST_ACTIVE;
            `ST_ACT_MRR:  state_q[bi] <= `ST_ACTIVE;
            `ST_MRW:      state_q[bi] <= `ST_IDLE;
            default:      state_q[bi] <= `ST_IDLE;
          endcase
        end
      end
    end
  endgenerate

  // ***************************************************
  // Burst owner, power-on flag and write masking
  // ***************************************************
  // Remember which bank holds the latest burst so terminate hits only it
  // A newer read or write takes ownership even when it goes to another bank
  always @(posedge clk) begin
    if (!nrst) begin
      lastBurstBank_q <= 2'h0;
      devPowerOn_q    <= 1'b1;
    end else begin
      if (take && (cmd == `CMD_RD || cmd == `CMD_WR)) begin
        lastBurstBank_q <= bankAddr;
      end
      if (take && resetCmd && devPowerOn_q) begin
        devPowerOn_q <= 1'b0;
      end
    end
  end

  // Writes storage per byte; mask sampled with the same edge as the data
  // Trade-off: one shared word stands in for the array, fed by any writing bank
  reg        writeActive;
  integer    wb;
  always @* begin
    writeActive = 1'b0;
    for (wb = 0; wb < `NUM_BANKS; wb = wb + 1) begin
      if (state_q[wb] == `ST_WRITING || state_q[wb] == `ST_WRITE_AP) begin
        writeActive = 1'b1;
      end
    end
  end

  // Next word lane by lane; a masked lane keeps its old byte
  wire [31:0] storedWord_d;
  genvar by;
  generate
    for (by = 0; by < 4; by = by + 1) begin : g_byte
      assign storedWord_d[8*by+7:8*by] = (writeActive && !write_byte_mask[by])
                                       ? writeData[8*by+7:8*by]
                                       : storedWord[8*by+7:8*by];
    end
  endgenerate

  // One clocked process owns the whole word, so each bit has a single driver
  always @(posedge clk) begin
    if (!nrst) begin
      storedWord <= 32'h00000000;
    end else begin
      storedWord <= storedWord_d;
    end
  end

  // ***************************************************
  // Registered outputs
  // ***************************************************
  // bankStates and allIdle both trail the internal state by one cycle
  // Flag rides one cycle after the offending command; state never moves on it
  always @(posedge clk) begin
    if (!nrst) begin
      bankStates <= {4{`ST_POWERON}};
      cmdIllegal <= 1'b0;
      allIdle    <= 1'b0;
    end else begin
      bankStates <= {state_q[3], state_q[2], state_q[1], state_q[0]};
      cmdIllegal <= cmdEnable && !isNop && !legal;
      allIdle    <= allBanksIdle;
    end
  end

endmodule
`default_nettype wire

// ==== design/bank_state_regs.vh ====
`ifndef BANK_STATE_REGS_VH
`define BANK_STATE_REGS_VH
// Command opcodes on the decoded command port
`define CMD_NOP      4'h0
`define CMD_ACT      4'h1
`define CMD_RD       4'h2
`define CMD_WR       4'h3
`define CMD_PRE      4'h4
`define CMD_PREALL   4'h5
`define CMD_MRR      4'h6
`define CMD_MRW      4'h7
`define CMD_BURSTEND 4'h8
`define CMD_REFPB    4'h9
`define CMD_REFAB    4'hA
`define CMD_SRE      4'hB
// Bank states
`define ST_IDLE      4'h0
`define ST_ACTING    4'h1
`define ST_ACTIVE    4'h2
`define ST_READING   4'h3
`define ST_WRITING   4'h4
`define ST_READ_AP   4'h5
`define ST_WRITE_AP  4'h6
`define ST_PRECHG    4'h7
`define ST_IDLE_MRR  4'h8
`define ST_ACT_MRR   4'h9
`define ST_MRW       4'hA
`define ST_RESETTING 4'hB
`define ST_RST_MRR   4'hC
`define ST_POWERON   4'hD
`define ST_REFRESH   4'hE
// Timing in ns and derived cycle counts at 100 ns per cycle
`define CLK_NS         100
`define PRECHARGE_NS   300
`define ACT_COL_NS     300
`define MODE_READ_NS   200
`define MODE_WRITE_NS  500
`define BURST_NS       400
`define REFRESH_NS     900
`define RESET_NS       1000
// Cycle counts: each ns figure rounded up to whole cycles, sized to the 4-bit timers
`define PRECHARGE_CYC  4'h3
`define ACT_COL_CYC    4'h3
`define MODE_READ_CYC  4'h2
`define MODE_WRITE_CYC 4'h5
`define BURST_CYC      4'h4
`define REFRESH_CYC    4'h9
`define RESET_CYC      4'hA
// Mode register address that acts as the reset command
`define MR_RESET_ADDR  8'h3F
`define NUM_BANKS      4
`endif

// ==== tb/cross_bank_command_legality_monitor.sv ====
`include "bank_state_regs.vh"
`default_nettype none
// ********************************
// Port checker of the bank tracker
// ********************************
module legality_monitor (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        cke,
  input wire logic        exitDone,
  input wire logic [3:0]  cmd,
  input wire logic [1:0]  bankAddr,
  input wire logic        autoPre,
  input wire logic [7:0]  modeAddr,
  input wire logic [31:0] writeData,
  input wire logic [3:0]  write_byte_mask,
  input wire logic [15:0] bankStates,
  input wire logic        cmdIllegal,
  input wire logic [31:0] storedWord,
  input wire logic        allIdle
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Enables held long enough to clear the synchronisers
  sequence s_ready;
    (cke && exitDone)[*6];
  endsequence
  // Refused commands may flag in either cycle, so both are excused
  property p_enters(logic hit, logic [3:0] code);
    s_ready ##0 hit |-> ##2 (cmdIllegal || $past(cmdIllegal)
      || bankStates[{$past(bankAddr, 2), 2'b00} +: 4] == code);
  endproperty
  a_act_opens_bank: assert property (p_enters(cmd == `CMD_ACT, `ST_ACTING))
    else $error("activate did not open the bank");
  a_pre_starts_close: assert property (p_enters(cmd == `CMD_PRE, `ST_PRECHG))
    else $error("precharge did not start");
  a_read_starts_burst: assert property (p_enters(cmd == `CMD_RD && !autoPre, `ST_READING))
    else $error("read did not start a burst");
  a_write_ap_burst: assert property (p_enters(cmd == `CMD_WR && autoPre, `ST_WRITE_AP))
    else $error("write with precharge did not start");
  a_reset_cmd_entry: assert property (s_ready ##0 (cmd == `CMD_MRW && modeAddr == `MR_RESET_ADDR
    && bankStates == 16'hDDDD && $past(cmd) == `CMD_NOP) |-> ##2 bankStates == 16'hBBBB)
    else $error("reset write did not start initialization");
  a_illegal_has_cause: assert property (cmdIllegal |->
    ($past(cmd) != `CMD_NOP || $past(cmd, 2) != `CMD_NOP))
    else $error("refusal flag without a command");
  a_nop_never_flags: assert property ((cmd == `CMD_NOP)[*2] |=> !cmdIllegal)
    else $error("no-op flagged as refused");
  a_cke_low_silent: assert property ((!cke)[*5] |=> !cmdIllegal)
    else $error("command judged while clock enable low");
  a_exit_wait_silent: assert property ((!exitDone)[*3] |=> !cmdIllegal)
    else $error("command judged before exit time");
  a_mask_keeps_word: assert property ((write_byte_mask == 4'hF)[*2] |=> $stable(storedWord))
    else $error("masked bytes were stored");
endmodule
bind bank_cmd_tracker legality_monitor i_mon (.clk, .nrst, .cke, .exitDone, .cmd, .bankAddr,
  .autoPre, .modeAddr, .writeData, .write_byte_mask, .bankStates, .cmdIllegal,
  .storedWord, .allIdle);
`default_nettype wire

// ==== tb/command_source_model.sv ====
`include "bank_state_regs.vh"
`default_nettype none
// *********************************
// Controller side of the command port
// *********************************
module command_source_model #(
  parameter int ACT_GAP = 2
) (
  input  wire logic        clk,
  output var  logic [3:0]  cmd,
  output var  logic [1:0]  bankAddr,
  output var  logic        autoPre,
  output var  logic [7:0]  modeAddr,
  output var  logic [31:0] writeData,
  output var  logic [3:0]  write_byte_mask
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap = 99;
  // Quiet port at start; mask high so nothing lands in storage
  initial begin
    cmd = `CMD_NOP;
    bankAddr = 2'h0;
    autoPre = 1'b0;
    modeAddr = 8'h00;
    writeData = 32'h0;
    write_byte_mask = 4'hF;
  end
  // Cycles since the last activate
  always @(posedge clk) begin
    gap <= (cmd == `CMD_ACT) ? 0 : gap + 1;
  end
  // One command for one edge; released address, precharge and mode lines carry junk, data and mask keep old values
  task automatic send(input logic [3:0] c, input logic [1:0] b, input logic ap,
                      input logic [7:0] ma, input logic [31:0] d, input logic [3:0] m);
    while (c == `CMD_ACT && gap < ACT_GAP) @(posedge clk);
    @(posedge clk);
    cmd <= c;
    bankAddr <= b;
    autoPre <= ap;
    modeAddr <= ma;
    writeData <= (m == 4'hF) ? ~writeData : d;
    write_byte_mask <= m;
    @(posedge clk);
    cmd <= `CMD_NOP;
    bankAddr <= ~b;
    autoPre <= ~ap;
    modeAddr <= ~ma;
  endtask
endmodule
`default_nettype wire

// ==== tb/cross_bank_command_legality_tb.sv ====
`include "bank_state_regs.vh"
`default_nettype none
// ******************************
// Bench for the bank tracker
// ******************************
module cross_bank_command_legality_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cke = 1'b1;
  logic        exitDone = 1'b1;
  logic [3:0]  cmd;
  logic [1:0]  bankAddr;
  logic        autoPre;
  logic [7:0]  modeAddr;
  logic [31:0] writeData;
  logic [3:0]  write_byte_mask;
  logic [15:0] bankStates;
  logic        cmdIllegal;
  logic [31:0] storedWord;
  logic        allIdle;
  logic        ill;
  int          n_errors = 0;
  int          samples_checked = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  command_source_model i_ctrl (.clk, .cmd, .bankAddr, .autoPre, .modeAddr, .writeData,
    .write_byte_mask);
  bank_cmd_tracker i_dut (.clk, .nrst, .cke, .exitDone, .cmd, .bankAddr, .autoPre, .modeAddr,
    .writeData, .write_byte_mask, .bankStates, .cmdIllegal, .storedWord, .allIdle);
  function automatic logic [3:0] st(input int b);
    return bankStates[4*b +: 4];
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("Compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Refusal may flag one or two edges on, so both cycles are gathered
  task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [7:0] ma = 8'h00,
                    input logic ap = 1'b0, input logic [31:0] d = 32'h0,
                    input logic [3:0] m = 4'hF);
    i_ctrl.send(c, b, ap, ma, d, m);
    #1;
    ill = cmdIllegal;
    @(posedge clk);
    #1;
    ill = ill | cmdIllegal;
  endtask
  // Bounded wait for a bank state; running out ends the run
  task automatic wait_st(input int b, input logic [3:0] s, input int lim);
    for (int k = 0; k < lim && st(b) !== s; k++) begin
      @(posedge clk);
      #1;
    end
    if (st(b) !== s) begin
      chk("bank wait", 32'(st(b)), 32'(s));
      end_sim();
    end
  endtask
  task automatic t_power();
    chk("reset states", 32'(bankStates), 32'hDDDD);
    chk("reset word", storedWord, 32'h0);
    go(`CMD_ACT, 2'd1);
    chk("early activate flag", 32'(ill), 32'h1);
    chk("early states", 32'(bankStates), 32'hDDDD);
    go(`CMD_MRW, 2'd0, 8'h3F);
    chk("reset entry", 32'(bankStates), 32'hBBBB);
    go(`CMD_MRR, 2'd0);
    chk("reset mode read", 32'(st(0)), 32'(`ST_RST_MRR));
    for (int b = 0; b < 4; b++) wait_st(b, `ST_IDLE, 20);
    @(posedge clk);
    #1;
    chk("idle flag", 32'(allIdle), 32'h1);
    $display("Test power-on done");
  endtask
  task automatic t_cross();
    go(`CMD_ACT, 2'd1);
    chk("bank1 opening", 32'(st(1)), 32'(`ST_ACTING));
    go(`CMD_MRR, 2'd0);
    chk("read beside opening", 32'(st(0)), 32'(`ST_IDLE_MRR));
    wait_st(0, `ST_IDLE, 6);
    wait_st(1, `ST_ACTIVE, 6);
    go(`CMD_ACT, 2'd2);
    chk("bank2 opening", 32'(st(2)), 32'(`ST_ACTING));
    go(`CMD_PRE, 2'd0);
    chk("idle bank closing", 32'(st(0)), 32'(`ST_PRECHG));
    go(`CMD_MRR, 2'd3);
    chk("read beside closing", 32'(st(3)), 32'(`ST_IDLE_MRR));
    wait_st(0, `ST_IDLE, 6);
    wait_st(2, `ST_ACTIVE, 6);
    $display("Test cross-bank done");
  endtask
  task automatic t_burst();
    go(`CMD_RD, 2'd1);
    chk("read burst", 32'(st(1)), 32'(`ST_READING));
    go(`CMD_BURSTEND, 2'd1);
    chk("terminate flag", 32'(ill), 32'h0);
    chk("terminate state", 32'(st(1)), 32'(`ST_ACTIVE));
    go(`CMD_WR, 2'd2, 8'h00, 1'b0, 32'hAABBCCDD, 4'h5);
    chk("write burst", 32'(st(2)), 32'(`ST_WRITING));
    wait_st(2, `ST_ACTIVE, 8);
    chk("masked word", storedWord, 32'hAA00CC00);
    go(`CMD_RD, 2'd1, 8'h00, 1'b1);
    chk("read with close", 32'(st(1)), 32'(`ST_READ_AP));
    repeat (2) @(posedge clk);
    go(`CMD_WR, 2'd2, 8'h00, 1'b1, 32'h11223344, 4'hA);
    chk("write beside close", 32'(st(2)), 32'(`ST_WRITE_AP));
    wait_st(1, `ST_IDLE, 12);
    wait_st(2, `ST_IDLE, 12);
    chk("second word", storedWord, 32'hAA22CC44);
    $display("Test bursts done");
  endtask
  task automatic t_misc();
    go(`CMD_ACT, 2'd3);
    wait_st(3, `ST_ACTIVE, 6);
    repeat (6) @(posedge clk);
    #1;
    chk("no-op hold", 32'(bankStates), 32'h2000);
    go(`CMD_MRR, 2'd3);
    chk("read from active", 32'(st(3)), 32'(`ST_ACT_MRR));
    wait_st(3, `ST_ACTIVE, 6);
    go(`CMD_MRW, 2'd0);
    chk("mode write flag", 32'(ill), 32'h1);
    @(posedge clk);
    cke <= 1'b0;
    repeat (4) @(posedge clk);
    go(`CMD_PRE, 2'd3);
    chk("enable low", 32'(bankStates), 32'h2000);
    chk("enable low flag", 32'(ill), 32'h0);
    @(posedge clk);
    cke <= 1'b1;
    exitDone <= 1'b0;
    repeat (4) @(posedge clk);
    go(`CMD_PRE, 2'd3);
    chk("exit pending", 32'(bankStates), 32'h2000);
    chk("exit pending flag", 32'(ill), 32'h0);
    @(posedge clk);
    exitDone <= 1'b1;
    repeat (4) @(posedge clk);
    go(`CMD_PREALL, 2'd0);
    chk("close all", 32'(bankStates), 32'h7777);
    for (int b = 0; b < 4; b++) wait_st(b, `ST_IDLE, 6);
    go(`CMD_REFAB, 2'd0);
    chk("refresh all", 32'(st(0)), 32'(`ST_REFRESH));
    for (int b = 0; b < 4; b++) wait_st(b, `ST_IDLE, 14);
    go(`CMD_REFPB, 2'd1);
    chk("refresh one", 32'(st(1)), 32'(`ST_REFRESH));
    go(`CMD_SRE, 2'd0);
    chk("busy self refresh", 32'(ill), 32'h1);
    wait_st(1, `ST_IDLE, 14);
    go(`CMD_SRE, 2'd0);
    chk("self refresh flag", 32'(ill), 32'h0);
    chk("self refresh states", 32'(bankStates), 32'h0000);
    $display("Test misc done");
  endtask
  // Reset for four edges, then the scenarios in order
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_power();
    t_cross();
    t_burst();
    t_misc();
    end_sim();
  end
endmodule
`default_nettype wire
